// ==== core/s8w_regs.svh ====
// Constants for the 8b/10b line coding and word alignment block
`ifndef S8W_REGS_SVH
`define S8W_REGS_SVH

`define S8W_CHAR_W   10
`define S8W_BYTE_W   8
`define S8W_LANES    4
`define S8W_WORD_W   40
`define S8W_DATA_W   32
`define S8W_LEFT_W   6
`define S8W_CODES    512
`define S8W_COMMA_N  10'h0FA
`define S8W_COMMA_P  10'h305
`define S8W_K28_5    8'hBC
`define S8W_BIT_LAST 4'h9
`define S8W_BAL6     3
`define S8W_BAL4     2
`define S8W_BAL10    5
`define S8W_X_D7     5'h07
`define S8W_X_K28    5'h1C
`define S8W_Y_7      3'h7
`define S8W_Y_3      3'h3
`define S8W_SIX_K28  6'h0F
`define S8W_FOUR_A7  4'h7

`endif

// ==== core/s8w_pkg.sv ====
// Types and code tables of the 8b/10b line coding block
package s8w_pkg;
`include "s8w_regs.svh"

    typedef enum logic [1:0] {
        S8W_W8  = 2'h0,
        S8W_W16 = 2'h1,
        S8W_W20 = 2'h2,
        S8W_W40 = 2'h3
    } s8w_width_t;

    typedef struct packed {
        logic [`S8W_WORD_W-1:0] data;
        logic [`S8W_LANES-1:0]  k;
    } s8w_word_t;

    localparam logic [5:0] S8W_SIX [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] S8W_FOUR [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

    // Characters per parallel word for each width
    function automatic logic [2:0] s8w_nchars(input s8w_width_t w);
        unique case (w)
            S8W_W8:  return 3'h1;
            S8W_W16: return 3'h2;
            S8W_W20: return 3'h2;
            S8W_W40: return 3'h4;
        endcase
    endfunction

    // Only K28.y and K23/27/29/30.7 are legal control characters
    function automatic logic s8w_kok(input logic [7:0] d, input logic k);
        logic [4:0] x;
        x = d[4:0];
        return !k || x == `S8W_X_K28 || (d[7:5] == `S8W_Y_7 &&
            (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E));
    endfunction

    // Returns {running disparity out, abcdei fghj}, rd 1 means positive
    function automatic logic [10:0] s8w_encode(input logic [7:0] d,
                                               input logic k,
                                               input logic rd);
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] six;
        logic [3:0] four;
        logic       rdm;
        logic       alt;
        x   = d[4:0];
        y   = d[7:5];
        six = (k && x == `S8W_X_K28) ? `S8W_SIX_K28 : S8W_SIX[x];
        if (rd && ($countones(six) != `S8W_BAL6 ||
                   (x == `S8W_X_D7 && !k)))
            six = ~six;
        rdm = ($countones(six) == `S8W_BAL6) ? rd : ~rd;
        alt = (y == `S8W_Y_7) && (k ||
              (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
              (rdm && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        four = alt ? `S8W_FOUR_A7 : S8W_FOUR[y];
        // Control groups also invert a balanced tail when the head left
        // the line negative, so a comma keeps its polarity in all ten bits
        if (k ? rdm ^ ($countones(four) == `S8W_BAL4 && y != `S8W_Y_3) :
                rdm && ($countones(four) != `S8W_BAL4 || y == `S8W_Y_3))
            four = ~four;
        return {($countones(four) == `S8W_BAL4) ? rdm : ~rdm, six, four};
    endfunction

    // Returns {invalid, k, data}; search by re-encoding every character
    function automatic logic [9:0] s8w_decode(input logic [9:0] c);
        logic [9:0]  r;
        logic [10:0] e;
        logic [8:0]  v;
        r = {2'h2, 8'h00};
        for (int i = 0; i < `S8W_CODES; i++) begin
            v = i[8:0];
            for (int j = 0; j < 2; j++) begin
                e = s8w_encode(v[7:0], v[8], j[0]);
                if (e[9:0] == c && s8w_kok(v[7:0], v[8]))
                    r = {1'b0, v};
            end
        end
        return r;
    endfunction
endpackage

// ==== core/s8w_enc.sv ====
// Four-lane 8b/10b encoder with running disparity
`timescale 1ns/1ps
module s8w_enc
    import s8w_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [`S8W_DATA_W-1:0]    data_i,
    input  wire logic [`S8W_LANES-1:0]     k_i,
    input  wire logic [2:0]                nch_i,
    input  wire logic                      adv_i,
    output logic      [`S8W_WORD_W-1:0]    codes_o,
    output logic                           rd_o
);
    logic        rd;
    logic        next_rd;
    logic [10:0] e;
    logic        r;

    // -------------------------------------------------------------
    // Lane chain, lane 0 first on the line
    // -------------------------------------------------------------
    always_comb begin
        r       = rd;
        next_rd = rd;
        codes_o = '0;
        e       = '0;
        for (int i = 0; i < `S8W_LANES; i++) begin
            e = s8w_encode(data_i[i*`S8W_BYTE_W +: `S8W_BYTE_W], k_i[i], r);
            codes_o[i*`S8W_CHAR_W +: `S8W_CHAR_W] = e[9:0];
            r = e[10];
            if (3'(i + 1) == nch_i)
                next_rd = r;
        end
        if (!adv_i)
            next_rd = rd;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd <= 1'b0;
        end else begin
            rd <= next_rd;
        end
    end

    assign rd_o = rd;
endmodule

// ==== core/s8w_top.sv ====
// 8b/10b coding, serializer, deserializer and comma word alignment
// Contract
// - Latch one, two or four codes, shift out serially
// - Encode each 8-bit character into 10 bits at width 8 or 16
// - Deserialize stream into one, two or four characters
// - Comma in either polarity fixes character boundary
// - Decode aligned code groups back to bytes at width 8 or 16
// - Parallel width 8, 16, 20 or 40
`timescale 1ns/1ps
module s8w_top
    import s8w_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire s8w_width_t WIDTH_I,
    input  wire s8w_word_t  TX_WORD_I,
    input  wire logic       TX_VALID_I,
    output logic            TX_READY_O,
    output logic            TX_SER_O,
    input  wire logic       RX_SER_I,
    output s8w_word_t       RX_WORD_O,
    output logic            RX_VALID_O,
    output logic [3:0]      RX_ERR_O,
    output logic            RX_ALIGNED_O
);
    logic [2:0]                 nch;
    logic                       raw;
    logic [`S8W_WORD_W-1:0]     codes;
    logic                       rd;
    logic                       load;
    logic [`S8W_WORD_W-1:0]     ld;
    logic [`S8W_LEFT_W-1:0]     nbits;
    logic [`S8W_WORD_W-1:0]     sh;
    logic [`S8W_WORD_W-1:0]     next_sh;
    logic [`S8W_LEFT_W-1:0]     left;
    logic [`S8W_LEFT_W-1:0]     next_left;
    logic                       next_ser;

    // Width picks lanes and whether the coder is bypassed
    assign nch = s8w_nchars(WIDTH_I);
    assign raw = WIDTH_I[1];
    assign nbits = `S8W_LEFT_W'(nch * `S8W_CHAR_W);

    // -------------------------------------------------------------
    // Transmit
    // -------------------------------------------------------------
    s8w_enc u_enc (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .data_i  (TX_WORD_I.data[`S8W_DATA_W-1:0]),
        .k_i     (TX_WORD_I.k),
        .nch_i   (nch),
        .adv_i   (load && !raw),
        .codes_o (codes),
        .rd_o    (rd)
    );

    // Ready while the last bit leaves, so words follow with no gap
    assign TX_READY_O = (left <= `S8W_LEFT_W'(1));
    assign load       = TX_READY_O && TX_VALID_I;

    always_comb begin
        ld = '0;
        for (int i = 0; i < `S8W_LANES; i++) begin
            if (3'(i) < nch)
                ld[`S8W_WORD_W-1-i*`S8W_CHAR_W -: `S8W_CHAR_W] = raw ?
                    TX_WORD_I.data[i*`S8W_CHAR_W +: `S8W_CHAR_W] :
                    codes[i*`S8W_CHAR_W +: `S8W_CHAR_W];
        end
    end

    always_comb begin
        next_sh   = sh;
        next_left = left;
        next_ser  = TX_SER_O;
        if (left != '0) begin
            next_ser  = sh[`S8W_WORD_W-1];
            next_sh   = sh << 1;
            next_left = left - `S8W_LEFT_W'(1);
        end
        if (load) begin
            next_sh   = ld;
            next_left = nbits;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sh       <= '0;
            left     <= '0;
            TX_SER_O <= 1'b0;
        end else begin
            sh       <= next_sh;
            left     <= next_left;
            TX_SER_O <= next_ser;
        end
    end

    // -------------------------------------------------------------
    // Receive
    // -------------------------------------------------------------
    logic [`S8W_CHAR_W-1:0]  rsh;
    logic [`S8W_CHAR_W-1:0]  next_rsh;
    logic [3:0]              cnt;
    logic [3:0]              next_cnt;
    logic [1:0]              lane;
    logic [1:0]              next_lane;
    logic                    next_aligned;
    logic                    hit;
    logic                    done;
    logic [9:0]              dec;
    logic [`S8W_WORD_W-1:0]  acc_raw;
    logic [`S8W_WORD_W-1:0]  next_raw;
    logic [`S8W_DATA_W-1:0]  acc_dat;
    logic [`S8W_DATA_W-1:0]  next_dat;
    logic [3:0]              acc_k;
    logic [3:0]              next_k;
    logic [3:0]              acc_e;
    logic [3:0]              next_e;
    s8w_word_t               next_word;
    logic [3:0]              next_err;
    logic                    next_valid;

    assign next_rsh = {rsh[`S8W_CHAR_W-2:0], RX_SER_I};
    assign hit  = next_rsh == `S8W_COMMA_N ||
                  next_rsh == `S8W_COMMA_P;
    assign done = hit || (RX_ALIGNED_O && cnt == `S8W_BIT_LAST);
    // One shared decoder: a character is decoded as it completes
    assign dec  = s8w_decode(next_rsh);

    always_comb begin
        next_cnt     = (hit || cnt == `S8W_BIT_LAST) ? '0 : cnt + 4'h1;
        next_aligned = RX_ALIGNED_O || hit;
        next_lane    = lane;
        next_raw     = acc_raw;
        next_dat     = acc_dat;
        next_k       = acc_k;
        next_e       = acc_e;
        next_word    = RX_WORD_O;
        next_err     = RX_ERR_O;
        next_valid   = 1'b0;
        // A comma off the current boundary restarts the word at lane 0
        if (hit && (!RX_ALIGNED_O || cnt != `S8W_BIT_LAST))
            next_lane = '0;
        if (done) begin
            next_raw[next_lane*`S8W_CHAR_W +: `S8W_CHAR_W] = next_rsh;
            next_dat[next_lane*`S8W_BYTE_W +: `S8W_BYTE_W] = dec[7:0];
            next_k[next_lane] = dec[8] && !raw;
            next_e[next_lane] = dec[9] && !raw;
            if (3'(next_lane) + 3'h1 == nch) begin
                next_valid     = 1'b1;
                next_word.data = raw ? next_raw :
                    {{(`S8W_WORD_W-`S8W_DATA_W){1'b0}}, next_dat};
                next_word.k    = next_k;
                next_err       = next_e;
                next_lane      = '0;
                next_k         = '0;
                next_e         = '0;
            end else begin
                next_lane = next_lane + 2'h1;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rsh          <= '0;
            cnt          <= '0;
            lane         <= '0;
            acc_raw      <= '0;
            acc_dat      <= '0;
            acc_k        <= '0;
            acc_e        <= '0;
            RX_ALIGNED_O <= 1'b0;
            RX_WORD_O    <= '0;
            RX_ERR_O     <= '0;
            RX_VALID_O   <= 1'b0;
        end else begin
            rsh          <= next_rsh;
            cnt          <= next_cnt;
            lane         <= next_lane;
            acc_raw      <= next_raw;
            acc_dat      <= next_dat;
            acc_k        <= next_k;
            acc_e        <= next_e;
            RX_ALIGNED_O <= next_aligned;
            RX_WORD_O    <= next_word;
            RX_ERR_O     <= next_err;
            RX_VALID_O   <= next_valid;
        end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_comma_seen;
        hit && !raw && nch == 3'h1;
    endsequence
    sequence s_comma_out;
        RX_VALID_O && RX_ALIGNED_O && cnt == '0;
    endsequence

    tx_shift_start_a: assert property (load |=>
        left == $past(nbits) ##1
        TX_SER_O == $past(ld[`S8W_WORD_W-1], 2))
        else $error("transmit count not loaded");
    tx_code_bal_a: assert property (load && !raw |->
        $countones(ld[`S8W_WORD_W-1 -: `S8W_CHAR_W]) inside {[4:6]})
        else $error("encoded group out of balance");
    rx_word_pace_a: assert property (RX_VALID_O |=>
        !RX_VALID_O [*8])
        else $error("receive words too close");
    rx_comma_word_a: assert property (s_comma_seen |=>
        s_comma_out)
        else $error("comma did not set boundary");
    rx_comma_dec_a: assert property (s_comma_seen |=>
        RX_WORD_O.data[7:0] == `S8W_K28_5 && RX_WORD_O.k[0] &&
        !RX_ERR_O[0])
        else $error("comma not decoded as K28.5");
    tx_ready_busy_a: assert property (left > `S8W_LEFT_W'(1) |->
        !TX_READY_O ##1 left == $past(left) - `S8W_LEFT_W'(1))
        else $error("ready while word in flight");
    tx_rd_flip_a: assert property (load && !raw && nch == 3'h1 &&
        $countones(ld[`S8W_WORD_W-1 -: `S8W_CHAR_W]) != `S8W_BAL10
        |=> rd != $past(rd))
        else $error("disparity not flipped");
endmodule

// ==== testbench/s8w_far_end.sv ====
// Remote transceiver model that feeds the serial receive line
`timescale 1ns/1ps
module s8w_far_end (
    input  wire logic clk_i,
    output logic      ser_o
);
    // ---------------------------------------------------------------
    // Serial source
    // ---------------------------------------------------------------
    logic bits_q [$];

    initial ser_o = 1'b0;

    // Idle line toggles every bit: no stale level, and no comma forms
    always @(negedge clk_i) begin
        if (bits_q.size() > 0)
            ser_o <= bits_q.pop_front();
        else
            ser_o <= ~ser_o;
    end

    // Queue a group string, first bit on the line is the MSB
    task automatic put(input logic [39:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            bits_q.push_back(v[i]);
    endtask
endmodule

// ==== testbench/s8w_top_tb_top.sv ====
// Self-checking testbench of the 8b/10b coding and alignment block
`timescale 1ns/1ps
`include "s8w_regs.svh"
module s8w_top_tb_top
    import s8w_pkg::*;
;
    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    s8w_width_t width = S8W_W8;
    s8w_word_t  tx_wd = '0;
    logic       tx_valid = 1'b0;
    logic       tx_ready;
    logic       tx_ser;
    logic       rx_ser;
    s8w_word_t  rx_word;
    logic       rx_valid;
    logic [3:0] rx_err;
    logic       rx_aligned;
    int         failures = 0;
    int         checked = 0;

    always #5 clk = ~clk;

    s8w_top dut_u (
        .CLK_I       (clk),
        .RST_I       (rst),
        .WIDTH_I     (width),
        .TX_WORD_I   (tx_wd),
        .TX_VALID_I  (tx_valid),
        .TX_READY_O  (tx_ready),
        .TX_SER_O    (tx_ser),
        .RX_SER_I    (rx_ser),
        .RX_WORD_O   (rx_word),
        .RX_VALID_O  (rx_valid),
        .RX_ERR_O    (rx_err),
        .RX_ALIGNED_O(rx_aligned)
    );

    s8w_far_end far_u (
        .clk_i(clk),
        .ser_o(rx_ser)
    );

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic cmp(input logic [43:0] got, input logic [43:0] exp,
                       input string msg);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic reset_dut();
        @(negedge clk);
        rst = 1'b1;
        repeat (10) @(negedge clk);
        cmp({40'h0, tx_ready, tx_ser, rx_valid, rx_aligned},
            {40'h0, 4'b1000}, "levels during reset");
        rst = 1'b0;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Offer one word and collect the serial bits up to the last one
    task automatic tx_word(input s8w_width_t w, input logic [43:0] word,
                           input logic [39:0] exp, input int n);
        logic [39:0] got;
        int          cnt;
        got = '0;
        cnt = 0;
        if (width !== w) begin
            @(negedge clk);
            width = w;
            @(negedge clk);
        end
        tx_wd = word;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && cnt < 100) begin
            @(negedge clk);
            cnt++;
        end
        // The taken edge still shows the old line level; the first bit
        // follows one edge later, and ready rises with one bit to go
        @(negedge clk);
        tx_valid = 1'b0;
        cnt = 0;
        do begin
            @(negedge clk);
            got = {got[38:0], tx_ser};
            cnt++;
        end while (tx_ready !== 1'b1 && cnt < 50);
        @(negedge clk);
        got = {got[38:0], tx_ser};
        cnt++;
        cmp(44'(cnt), 44'(n), "tx bit count");
        cmp({4'h0, got}, {4'h0, exp}, "tx serial bits");
        $display("tx word done, width %0d", w);
    endtask

    // Align on a comma from reset, then judge the first word out
    task automatic rx_case(input s8w_width_t w, input logic [39:0] bits,
                           input int n, input logic [43:0] mask,
                           input logic [43:0] exp, input logic [3:0] err);
        logic       quiet;
        logic [3:0] emask;
        int         cnt;
        quiet = 1'b1;
        cnt = 0;
        emask = (w == S8W_W8) ? 4'h1 : (w == S8W_W16) ? 4'h3 : 4'hF;
        width = w;
        reset_dut();
        repeat (23) begin
            @(negedge clk);
            quiet = quiet & (rx_valid === 1'b0) & (rx_aligned === 1'b0);
        end
        cmp({43'h0, quiet}, 44'h1, "output before comma");
        far_u.put(bits, n);
        do begin
            @(negedge clk);
            cnt++;
        end while (rx_valid !== 1'b1 && cnt < 80);
        cmp({43'h0, rx_valid}, 44'h1, "rx word valid");
        cmp(rx_word & mask, exp, "rx word");
        cmp({40'h0, rx_err & emask}, {40'h0, err}, "rx flags");
        cmp({43'h0, rx_aligned}, 44'h1, "aligned flag");
        $display("rx case done, width %0d", w);
    endtask

    // ---------------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        reset_dut();
        tx_word(S8W_W8, {40'hBC, 4'h1}, `S8W_COMMA_N, 10);
        tx_word(S8W_W8, {40'hBC, 4'h1}, `S8W_COMMA_P, 10);
        tx_word(S8W_W8, {40'hB5, 4'h0}, 40'h2AA, 10);
        tx_word(S8W_W16, {40'h4AB5, 4'h0},
                {20'h0, 10'h2AA, 10'h155}, 20);
        tx_word(S8W_W20, {20'h0, 10'h2AA, 10'h0FA, 4'h0},
                {20'h0, 10'h0FA, 10'h2AA}, 20);
        tx_word(S8W_W40, {10'h155, 10'h2AA, 10'h0FA, 10'h305, 4'hF},
                {10'h305, 10'h0FA, 10'h2AA, 10'h155}, 40);
        rx_case(S8W_W8, {30'h0, `S8W_COMMA_N}, 10, {32'h0, 8'hFF, 4'h1},
                {32'h0, `S8W_K28_5, 4'h1}, 4'h0);
        rx_case(S8W_W16, {20'h0, `S8W_COMMA_P, 10'h155}, 20,
                {24'h0, 16'hFFFF, 4'h3},
                {24'h0, 16'h4ABC, 4'h1}, 4'h0);
        rx_case(S8W_W16, {20'h0, `S8W_COMMA_N, 10'h000}, 20,
                {24'h0, 16'h00FF, 4'h3},
                {24'h0, 16'h00BC, 4'h1}, 4'h2);
        rx_case(S8W_W20, {20'h0, `S8W_COMMA_N, 10'h2AA}, 20,
                {20'h0, 20'hFFFFF, 4'hF},
                {20'h0, 10'h2AA, 10'h0FA, 4'h0}, 4'h0);
        rx_case(S8W_W40, {`S8W_COMMA_N, 10'h2AA, 10'h155, 10'h2AA}, 40,
                {44{1'b1}},
                {10'h2AA, 10'h155, 10'h2AA, 10'h0FA, 4'h0}, 4'h0);
        end_of_test();
    end

    // Whole run needs about 430 cycles; over ten times that means a hang
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule
